// file: verification/sdc_host_model.sv
// Host controller model that sends serial frames and collects readback
`timescale 1ns/1ps
module sdc_host_model (
	input wire logic i_sys_clk,
	input wire logic i_ser_readback,
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_ser_le
);
	// ==========
	// Frame driver
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_ser_le = 1'b0;
	end
	// Readback is taken while serial clock is low, so it never races a shift
	task automatic send(input logic [31:0] f, output logic [31:0] rb);
		for (int i = 31; i >= 0; i--) begin
			@(posedge i_sys_clk);
			o_ser_clk <= 1'b0;
			o_ser_data <= f[i];
			@(posedge i_sys_clk);
			rb[i] = i_ser_readback;
			o_ser_clk <= 1'b1;
		end
		@(posedge i_sys_clk);
		o_ser_clk <= 1'b0;
		@(posedge i_sys_clk);
		o_ser_le <= 1'b1;
		o_ser_data <= ~f[0];
		@(posedge i_sys_clk);
		o_ser_le <= 1'b0;
	endtask
endmodule

// file: verification/tb.sv
// Self-checking bench for the divider control register bank
`timescale 1ns/1ps
module tb;
	import sdc_pkg::*;
	// ==========
	// Signals and instances
	logic i_sys_clk, i_rst_b, sclk, sdat, sle, srb, pen, byp, shut, rsel, cal;
	logic [4:0] pg;
	logic [1:0] core;
	logic [8:0] ratio;
	logic [11:0] fbd;
	logic [21:0] num;
	logic [31:0] rb;
	sdc_order_type ord;
	sdc_dither_type dith;
	int mismatches, n_tests, ncal, c;
	sdc_host_model host (.i_sys_clk(i_sys_clk), .i_ser_readback(srb), .o_ser_clk(sclk), .o_ser_data(sdat),
		.o_ser_le(sle));
	sdc_regs dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ser_clk(sclk), .i_ser_data(sdat), .i_ser_le(sle),
		.o_ser_readback(srb), .o_pump_gain(pg), .o_pump_enable(pen), .o_start_core_select(core),
		.o_modulator_order(ord), .o_ref_div_ratio(ratio), .o_ref_bypass(byp), .o_dither_mode(dith),
		.o_fraction_shutdown(shut), .o_feedback_div(fbd), .o_fraction_numerator(num),
		.o_part_code_readback_sel(rsel), .o_cal_start(cal));
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) if (cal === 1'b1) ncal++;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task wr(input logic [31:0] f);
		host.send(f, rb);
		repeat (2) @(negedge i_sys_clk);
	endtask
	// ==========
	// Scenarios
	task t_div;
		logic [7:0] rd;
		logic [4:0] g;
		for (int i = 0; i < 8; i++) begin
			rd = (i == 7) ? 8'hFF : 8'(i);
			g = (i == 0) ? 5'h00 : 5'(i * 4 + 3);
			c = ncal;
			wr({g, 2'(i), 3'(i), rd, 10'(i * 73), 4'h1});
			check(pg, g);
			check(pen, g != 0);
			check(core, i % 4);
			check(ord, (i < 4) ? 32'(i) : 32'(ORD_RESERVED));
			check(ratio, (rd == 0) ? 256 : rd);
			check(byp, rd == 1);
			check(num[21:12], 10'(i * 73));
			check(ncal, c);
		end
		$display("t_div done");
	endtask
	task t_freq;
		logic [11:0] nl;
		for (int i = 0; i < 4; i++) begin
			nl = (i == 3) ? 12'h000 : 12'(i * 1365 + 1);
			c = ncal;
			wr({1'b0, 2'(i), 1'(i % 2), 12'(14 + i), nl, 4'h0});
			check(dith, i);
			check(shut, i == 3);
			check(fbd, 14 + i);
			check(num, {10'h1FF, nl});
			check(ncal, c + 1 - i % 2);
		end
		$display("t_freq done");
	endtask
	task t_read;
		wr(32'hA5C3_9E71);
		wr(32'hA5C3_9E71);
		wr({1'b1, 2'h3, 1'b1, 12'd17, 12'h000, 4'h0});
		check(rb[31:4], 28'hA5C39E7);
		check(rsel, 1'b1);
		c = ncal;
		wr(32'hFFFF_FFF5);
		check(rb[31:4], {1'b0, 2'h3, 1'b1, 12'd17, 12'h000});
		check(pg, 5'h14);
		check(ncal, c);
		wr(32'hA5C3_9E71);
		wr({1'b0, 2'h3, 1'b1, 12'd17, 12'h000, 4'h0});
		check(rb, PART_CODE_DEFAULT);
		check(rsel, 1'b0);
		wr(32'hFFFF_FFF5);
		wr(32'hA5C3_9E71);
		check(rb, 32'h0000_0000);
		check(fbd, 12'd17);
		$display("t_read done");
	endtask
	initial begin
		i_rst_b = 1'b0;
		repeat (5) @(negedge i_sys_clk);
		check(ratio, 9'h100);
		check(ord, ORD_INTEGER);
		check({pen, shut, cal}, 3'b000);
		@(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		t_div;
		t_freq;
		t_read;
		finish_test;
	end
	// Frames take about 70 cycles each; the span leaves ample margin
	initial begin
		#60000;
		mismatches++;
		finish_test;
	end
endmodule

// file: verilog/sdc_pkg.sv
// Constants and types for the synthesizer divider control register bank
//
// Behaviour
// (R01) Pump gain zero tri-states, else n times unit
// (R02) Host zeroes bleed at low pump current
// (R03) Calibration starts at selected core zero to three
// (R04) Host avoids core three below 2.2 GHz
// (R05) Modulator order: integer, first..third, rest reserved
// (R06) Reference divide: zero 256, one bypass
// (R07) Frequency write calibrates unless suppress bit set
// (R08) Host leaves calibration on when retuning
// (R09) Readback select: registers or part code
// (R10) Dither weak/medium/strong/disabled; disabled shuts fraction
// (R11) Host disables dither when numerator zero
// (R12) Host keeps feedback divide within order limits
// (R13) Numerator joins upper 21:12 and lower 11:0
// (R14) Host keeps denominator nonzero outside integer mode
// (R15) Host keeps numerator below denominator
package sdc_pkg;
	// ==========================================
	// Serial frame
	localparam int FRAME_W = 32;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_FREQ = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_DIV = 4'h1;
	// ==========================================
	// Divider and pump configuration fields
	localparam int PG_LSB = 27;
	localparam int PG_W = 5;
	localparam int CORE_LSB = 25;
	localparam int CORE_W = 2;
	localparam int ORD_LSB = 22;
	localparam int ORD_W = 3;
	localparam int RDIV_LSB = 14;
	localparam int RDIV_W = 8;
	localparam int NUMH_LSB = 4;
	localparam int NUMH_W = 10;
	// ==========================================
	// Frequency control fields
	localparam int RBSEL_BIT = 31;
	localparam int DITH_LSB = 29;
	localparam int DITH_W = 2;
	localparam int CALSUP_BIT = 28;
	localparam int FBD_LSB = 16;
	localparam int FBD_W = 12;
	localparam int NUML_LSB = 4;
	localparam int NUML_W = 12;
	localparam int NUM_W = NUMH_W + NUML_W;
	// ==========================================
	// Reset values and codes
	localparam logic [FRAME_W-1:0] DIV_RESET = 32'h0000_0000;
	localparam logic [FRAME_W-1:0] FREQ_RESET = 32'h0000_0000;
	localparam logic [DITH_W-1:0] DITH_OFF = 2'h3;
	localparam logic [RDIV_W:0] RDIV_FULL = 9'h100;
	localparam logic [RDIV_W-1:0] RDIV_BYPASS = 8'h01;
	// Arbitrary neutral value for the part code
	localparam logic [FRAME_W-1:0] PART_CODE_DEFAULT = 32'h0000_5A5A;

	typedef enum logic [2:0] {
		ORD_INTEGER = 3'b000,
		ORD_FIRST = 3'b001,
		ORD_SECOND = 3'b010,
		ORD_THIRD = 3'b011,
		ORD_RESERVED = 3'b100
	} sdc_order_type;

	typedef enum logic [1:0] {
		DITH_WEAK = 2'b00,
		DITH_MEDIUM = 2'b01,
		DITH_STRONG = 2'b10,
		DITH_DISABLED = 2'b11
	} sdc_dither_type;
endpackage

// file: verilog/sdc_regs.sv
// Three-wire serial register bank of the synthesizer divider control
`timescale 1ns/1ps
module sdc_regs #(
	parameter logic [31:0] PART_CODE = sdc_pkg::PART_CODE_DEFAULT
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_ser_clk,
	input wire logic i_ser_data,
	input wire logic i_ser_le,
	output logic o_ser_readback,
	output logic [sdc_pkg::PG_W-1:0] o_pump_gain,
	output logic o_pump_enable,
	output logic [sdc_pkg::CORE_W-1:0] o_start_core_select,
	output sdc_pkg::sdc_order_type o_modulator_order,
	output logic [sdc_pkg::RDIV_W:0] o_ref_div_ratio,
	output logic o_ref_bypass,
	output sdc_pkg::sdc_dither_type o_dither_mode,
	output logic o_fraction_shutdown,
	output logic [sdc_pkg::FBD_W-1:0] o_feedback_div,
	output logic [sdc_pkg::NUM_W-1:0] o_fraction_numerator,
	output logic o_part_code_readback_sel,
	output logic o_cal_start
);
	import sdc_pkg::*;

	// ==========================================
	// Serial edge detection
	logic sclk_q;
	logic le_q;
	logic sclk_rise;
	logic le_rise;
	logic [FRAME_W-1:0] shift_q;
	logic [FRAME_W-1:0] div_q;
	logic [FRAME_W-1:0] freq_q;
	logic [FRAME_W-1:0] rb_q;
	logic [ADDR_W-1:0] frame_addr;
	logic latch_freq;
	logic latch_div;

	function automatic sdc_order_type decode_order(input logic [ORD_W-1:0] code);
		case (code)
			ORD_INTEGER: decode_order = ORD_INTEGER;
			ORD_FIRST: decode_order = ORD_FIRST;
			ORD_SECOND: decode_order = ORD_SECOND;
			ORD_THIRD: decode_order = ORD_THIRD;
			default: decode_order = ORD_RESERVED;
		endcase
	endfunction

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sclk_q <= 1'b0;
			le_q <= 1'b0;
		end else begin
			sclk_q <= i_ser_clk;
			le_q <= i_ser_le;
		end
	end

	assign sclk_rise = i_ser_clk & ~sclk_q;
	assign le_rise = i_ser_le & ~le_q;
	assign frame_addr = shift_q[ADDR_W-1:0];
	assign latch_freq = le_rise && (frame_addr == ADDR_FREQ);
	assign latch_div = le_rise && (frame_addr == ADDR_DIV);

	// ==========================================
	// Shift in, MSB first, while latch enable is low
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shift_q <= '0;
		end else if (sclk_rise && !i_ser_le) begin
			shift_q <= {shift_q[FRAME_W-2:0], i_ser_data};
		end
	end

	// ==========================================
	// Register latch on rising latch enable
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_q <= DIV_RESET;
		end else if (latch_div) begin
			div_q <= shift_q;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			freq_q <= FREQ_RESET;
		end else if (latch_freq) begin
			freq_q <= shift_q;
		end
	end

	// Calibration request, suppressed by the bit in the same frame
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cal_start <= 1'b0;
		end else begin
			o_cal_start <= latch_freq && !shift_q[CALSUP_BIT]; // R07
		end
	end

	// ==========================================
	// Readback: loaded at each latch, shifted out on each serial clock
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rb_q <= '0;
		end else if (le_rise) begin
			if (freq_q[RBSEL_BIT]) begin
				rb_q <= PART_CODE; // R09
			end else if (frame_addr == ADDR_FREQ) begin
				rb_q <= freq_q; // R09
			end else if (frame_addr == ADDR_DIV) begin
				rb_q <= div_q;
			end else begin
				rb_q <= '0;
			end
		end else if (sclk_rise && !i_ser_le) begin
			rb_q <= {rb_q[FRAME_W-2:0], 1'b0};
		end
	end

	assign o_ser_readback = rb_q[FRAME_W-1];

	// ==========================================
	// Field decode; outputs follow the stored words directly
	assign o_pump_gain = div_q[PG_LSB +: PG_W];
	assign o_pump_enable = (o_pump_gain != '0); // R01
	assign o_start_core_select = div_q[CORE_LSB +: CORE_W]; // R03
	assign o_modulator_order = decode_order(div_q[ORD_LSB +: ORD_W]); // R05
	// Zero stands for the full count, which needs one extra bit
	assign o_ref_div_ratio = (div_q[RDIV_LSB +: RDIV_W] == '0) ? RDIV_FULL : {1'b0, div_q[RDIV_LSB +: RDIV_W]}; // R06
	assign o_ref_bypass = (div_q[RDIV_LSB +: RDIV_W] == RDIV_BYPASS); // R06
	assign o_dither_mode = sdc_dither_type'(freq_q[DITH_LSB +: DITH_W]); // R10
	assign o_fraction_shutdown = (freq_q[DITH_LSB +: DITH_W] == DITH_OFF); // R10
	assign o_feedback_div = freq_q[FBD_LSB +: FBD_W];
	assign o_fraction_numerator = {div_q[NUMH_LSB +: NUMH_W], freq_q[NUML_LSB +: NUML_W]}; // R13
	assign o_part_code_readback_sel = freq_q[RBSEL_BIT];

	// ==========================================
	// Checks
	// Field loads, checked against the frame that was latched; order decode checked against the stored word
	property p_pump_tri;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_div |=> o_pump_gain == $past(shift_q[PG_LSB +: PG_W])
			&& o_pump_enable == ($past(shift_q[PG_LSB +: PG_W]) != '0);
	endproperty
	a_pump_tri: assert property (p_pump_tri) else $error("pump enable wrong"); // R01

	property p_core_load;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_div |=> o_start_core_select == $past(shift_q[CORE_LSB +: CORE_W]);
	endproperty
	a_core_load: assert property (p_core_load) else $error("start core not loaded"); // R03

	property p_order;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(div_q[ORD_LSB +: ORD_W] > ORD_THIRD) == (o_modulator_order == ORD_RESERVED);
	endproperty
	a_order: assert property (p_order) else $error("order decode wrong"); // R05

	property p_ref_div;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_div |=> (o_ref_div_ratio == RDIV_FULL) == ($past(shift_q[RDIV_LSB +: RDIV_W]) == '0);
	endproperty
	a_ref_div: assert property (p_ref_div) else $error("reference ratio wrong"); // R06

	property p_bypass;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_div |=> o_ref_bypass == ($past(shift_q[RDIV_LSB +: RDIV_W]) == RDIV_BYPASS);
	endproperty
	a_bypass: assert property (p_bypass) else $error("reference bypass wrong"); // R06

	property p_cal_go;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(latch_freq && !shift_q[CALSUP_BIT]) |=> o_cal_start ##1 !o_cal_start;
	endproperty
	a_cal_go: assert property (p_cal_go) else $error("calibration not one pulse"); // R07

	property p_cal_cause;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		o_cal_start |-> $past(latch_freq) && !freq_q[CALSUP_BIT];
	endproperty
	a_cal_cause: assert property (p_cal_cause) else $error("calibration without cause"); // R07

	property p_cal_quiet;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(latch_freq && shift_q[CALSUP_BIT]) |=> !o_cal_start;
	endproperty
	a_cal_quiet: assert property (p_cal_quiet) else $error("suppressed calibration started"); // R07

	// Readback path: load source at each latch, then a plain left shift
	property p_rb_part;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(le_rise && freq_q[RBSEL_BIT]) |=> rb_q == PART_CODE;
	endproperty
	a_rb_part: assert property (p_rb_part) else $error("part code not loaded"); // R09

	property p_rb_freq;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(le_rise && !freq_q[RBSEL_BIT] && frame_addr == ADDR_FREQ) |=> rb_q == $past(freq_q);
	endproperty
	a_rb_freq: assert property (p_rb_freq) else $error("frequency word not loaded"); // R09

	property p_rb_div;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(le_rise && !freq_q[RBSEL_BIT] && frame_addr == ADDR_DIV) |=> rb_q == $past(div_q);
	endproperty
	a_rb_div: assert property (p_rb_div) else $error("divider word not loaded"); // R09

	property p_rb_shift;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		(sclk_rise && !i_ser_le) |=> rb_q == {$past(rb_q[FRAME_W-2:0]), 1'b0};
	endproperty
	a_rb_shift: assert property (p_rb_shift) else $error("readback shift wrong"); // R09

	property p_dither;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_freq |=> o_fraction_shutdown == ($past(shift_q[DITH_LSB +: DITH_W]) == DITH_OFF);
	endproperty
	a_dither: assert property (p_dither) else $error("fraction shutdown wrong"); // R10

	property p_num;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_freq |=> o_fraction_numerator[NUML_W-1:0] == $past(shift_q[NUML_LSB +: NUML_W])
			&& $stable(o_fraction_numerator[NUM_W-1:NUML_W]);
	endproperty
	a_num: assert property (p_num) else $error("numerator join wrong"); // R13

	property p_num_hi;
		@(posedge i_sys_clk) disable iff (!i_rst_b)
		latch_div |=> o_fraction_numerator[NUM_W-1:NUML_W] == $past(shift_q[NUMH_LSB +: NUMH_W])
			&& $stable(o_fraction_numerator[NUML_W-1:0]);
	endproperty
	a_num_hi: assert property (p_num_hi) else $error("numerator upper half wrong"); // R13

	c_cal: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_cal_start);
	c_suppressed: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) latch_freq && shift_q[CALSUP_BIT]);
	c_part: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) le_rise && freq_q[RBSEL_BIT]);
	c_div: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) latch_div);
	c_reserved: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) o_modulator_order == ORD_RESERVED);
endmodule
